// file: bdp_defs.vh
`ifndef BDP_DEFS_VH
`define BDP_DEFS_VH

// ---------------------------------------------------------------
// routing select codes
// ---------------------------------------------------------------
`define BDP_SEL_W 2
`define BDP_SEL_SAFE 2'h0
`define BDP_SEL_ENGINE 2'h1
`define BDP_SEL_ALT 2'h2
`define BDP_SEL_NONE 2'h3

// ---------------------------------------------------------------
// channel count and safe pin levels
// ---------------------------------------------------------------
`define BDP_NUM_CH 2
`define BDP_SAFE_TXD 1'h0
`define BDP_SAFE_TXREQ 1'h1
`define BDP_SAFE_RXD 1'h1

`endif

// file: bdp_port_mux.v

`include "bdp_defs.vh"

module bdp_port_mux #(
   parameter NUM_CH = `BDP_NUM_CH
) (
   // clock and reset
   input wire clk,
   input wire resetn,
   // power state: low while pad supply is not yet stable
   input wire power_good,
   // routing configuration, one select per channel
   input wire [2*NUM_CH-1:0] route_sel,
   input wire route_load,
   // protocol engine side
   input wire [NUM_CH-1:0] engine_txd,
   input wire [NUM_CH-1:0] engine_tx_request_n,
   output wire [NUM_CH-1:0] engine_rxd,
   // alternate internal function side
   input wire [NUM_CH-1:0] alt_txd_out,
   input wire [NUM_CH-1:0] alt_txd_oe,
   input wire [NUM_CH-1:0] alt_txreq_out,
   input wire [NUM_CH-1:0] alt_txreq_oe,
   output wire [NUM_CH-1:0] alt_rxd_in,
   // external pins toward the bus drivers
   output wire [NUM_CH-1:0] txd_pin_out,
   output wire [NUM_CH-1:0] txd_pin_oe,
   output wire [NUM_CH-1:0] tx_request_pin_out,
   output wire [NUM_CH-1:0] tx_request_pin_oe,
   input wire [NUM_CH-1:0] rxd_pin
);

   // ---------------------------------------------------------------
   // local codes and helpers
   // ---------------------------------------------------------------

   // route codes, one field of SEL_W bits per channel
   localparam SEL_W = `BDP_SEL_W;
   localparam [SEL_W-1:0] CODE_SAFE = `BDP_SEL_SAFE;
   localparam [SEL_W-1:0] CODE_ENGINE = `BDP_SEL_ENGINE;
   localparam [SEL_W-1:0] CODE_ALT = `BDP_SEL_ALT;
   localparam [SEL_W-1:0] CODE_NONE = `BDP_SEL_NONE;

   // compare one channel's select field against a route code;
   // every branch of the pin logic and both receive owners use it
   function route_is;
      input [SEL_W-1:0] chan_code;
      input [SEL_W-1:0] want_code;
      begin
         route_is = (chan_code == want_code);
      end
   endfunction

   // pick the select field of one channel out of the packed word,
   // channel 0 in the lowest field
   function [SEL_W-1:0] chan_field;
      input [SEL_W*NUM_CH-1:0] packed_sel;
      input integer idx;
      begin
         chan_field = packed_sel[SEL_W*idx +: SEL_W];
      end
   endfunction

   // receive output of one consumer: the pin when it owns the link,
   // the idle level otherwise so an unrouted consumer sees a quiet line
   function rx_or_idle;
      input owns_link;
      input pin_level;
      begin
         if (owns_link) begin
            rx_or_idle = pin_level;
         end else begin
            rx_or_idle = `BDP_SAFE_RXD;
         end
      end
   endfunction

   // ---------------------------------------------------------------
   // routing select register
   // ---------------------------------------------------------------

   // the select word and a flag that says software has loaded it;
   // both are lost on reset and on supply loss, so a fresh load is
   // needed before any pin leaves its passive level
   reg [SEL_W*NUM_CH-1:0] sel;
   reg configured;
   reg [SEL_W*NUM_CH-1:0] next_sel;
   reg next_configured;

   // next select: supply loss forces the safe route and forgets the setup
   always @* begin
      next_sel = sel;
      next_configured = configured;
      if (!power_good) begin
         next_sel = {NUM_CH{CODE_SAFE}};
         next_configured = 1'b0;
      end else if (route_load) begin
         // one select word serves the channels of a single cluster
         next_sel = route_sel;
         next_configured = 1'b1;
      end
   end

   // select flops; reset lands on the safe route until software loads one
   always @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         sel <= {NUM_CH{CODE_SAFE}};
         configured <= 1'b0;
      end else begin
         sel <= next_sel;
         configured <= next_configured;
      end
   end

   // ---------------------------------------------------------------
   // per-channel pin logic
   // ---------------------------------------------------------------

   // every channel gets an identical, independent copy of the pin
   // logic; nothing is shared between channels except the supply flag
   // and the configured flag, so one channel can be routed to the
   // engine while the other stays passive or serves another function
   genvar ch;
   generate
      for (ch = 0; ch < NUM_CH; ch = ch + 1) begin : g_ch
         // each channel, A and B, has its own select field and pin flops
         wire [SEL_W-1:0] code;
         wire safe;
         wire eng_owns;
         wire alt_owns;

         // pin flops and their next values
         reg txd_q;
         reg txd_oe_q;
         reg req_q;
         reg req_oe_q;
         reg erx_q;
         reg arx_q;
         reg next_txd;
         reg next_txd_oe;
         reg next_req;
         reg next_req_oe;
         reg next_erx;
         reg next_arx;

         assign code = chan_field(sel, ch);
         // unconfigured, depowered or safe code all mean the passive pin state
         assign safe = !configured || !power_good || route_is(code, CODE_SAFE);
         // which consumer owns the receive line this cycle
         assign eng_owns = !safe && route_is(code, CODE_ENGINE);
         assign alt_owns = !safe && route_is(code, CODE_ALT);

         // next pin state from the route in force
         always @* begin
            // passive defaults: request high, transmit low, both driven
            next_txd = `BDP_SAFE_TXD;
            next_txd_oe = 1'b1;
            next_req = `BDP_SAFE_TXREQ;
            next_req_oe = 1'b1;
            next_erx = rx_or_idle(eng_owns, rxd_pin[ch]);
            next_arx = rx_or_idle(alt_owns, rxd_pin[ch]);
            if (safe) begin
               // driven passive levels; the high request keeps the driver quiet
               next_txd = `BDP_SAFE_TXD;
               next_req = `BDP_SAFE_TXREQ;
            end else if (route_is(code, CODE_ENGINE)) begin
               // protocol engine owns the link, bit for bit
               next_txd = engine_txd[ch];
               next_req = engine_tx_request_n[ch];
            end else if (route_is(code, CODE_ALT)) begin
               // another internal function owns the pins; no protocol duty here
               next_txd = alt_txd_out[ch];
               next_txd_oe = alt_txd_oe[ch];
               next_req = alt_txreq_out[ch];
               next_req_oe = alt_txreq_oe[ch];
            end else if (route_is(code, CODE_NONE)) begin
               // routed to nothing: both pins released, external pulls take over
               next_txd_oe = 1'b0;
               next_req_oe = 1'b0;
            end
         end

         // pin flops; reset drives the passive levels straight away,
         // without waiting for a clock edge
         always @(posedge clk or negedge resetn) begin
            if (!resetn) begin
               txd_q <= `BDP_SAFE_TXD;
               txd_oe_q <= 1'b1;
               req_q <= `BDP_SAFE_TXREQ;
               req_oe_q <= 1'b1;
               erx_q <= `BDP_SAFE_RXD;
               arx_q <= `BDP_SAFE_RXD;
            end else begin
               txd_q <= next_txd;
               txd_oe_q <= next_txd_oe;
               req_q <= next_req;
               req_oe_q <= next_req_oe;
               erx_q <= next_erx;
               arx_q <= next_arx;
            end
         end

         // outputs come straight from the pin flops
         assign txd_pin_out[ch] = txd_q;
         assign txd_pin_oe[ch] = txd_oe_q;
         assign tx_request_pin_out[ch] = req_q;
         assign tx_request_pin_oe[ch] = req_oe_q;
         assign engine_rxd[ch] = erx_q;
         assign alt_rxd_in[ch] = arx_q;
      end
   endgenerate

endmodule

// file: bdp_bus_driver_model.sv
module bdp_bus_driver_model (
   input wire [1:0] txd_pin_out, txd_pin_oe, tx_request_pin_out, tx_request_pin_oe,
   output wire [1:0] rxd_pin);
   timeunit 1ns;
   timeprecision 1ps;
   // released request pulls high, released data pulls low, idle channel reads high
   assign rxd_pin = (txd_pin_out & txd_pin_oe) | tx_request_pin_out | ~tx_request_pin_oe;
endmodule

// file: bdp_port_mux_chk.sv
module bdp_port_mux_chk #(parameter NUM_CH = 2) (input wire clk, input wire resetn,
   input wire power_good, input wire route_load, input wire [2*NUM_CH-1:0] route_sel,
   input wire [NUM_CH-1:0] engine_txd, engine_tx_request_n, rxd_pin, engine_rxd, txd_pin_out,
   input wire [NUM_CH-1:0] txd_pin_oe, tx_request_pin_out, tx_request_pin_oe);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge clk); endclocking
   default disable iff (!resetn);
   // pins in the passive state
   wire safe = ~|txd_pin_out & &txd_pin_oe & &tx_request_pin_out & &tx_request_pin_oe;
   property p_rst; $rose(resetn) |-> safe; endproperty
   a_rst: assert property (p_rst) else $error("pins not passive after reset");
   property p_pwr; !power_good |=> safe; endproperty
   a_pwr: assert property (p_pwr) else $error("pins not passive while depowered");
   property p_cfg; !power_good ##1 (power_good && !route_load)[*3] |-> safe; endproperty
   a_cfg: assert property (p_cfg) else $error("route kept after supply loss");
   property p_req; route_load && power_good && route_sel == 4'h5 ##1 (power_good && !route_load)[*3]
      |-> tx_request_pin_out == $past(engine_tx_request_n) && &tx_request_pin_oe; endproperty
   a_req: assert property (p_req) else $error("request pin not following engine");
   property p_eng; route_load && power_good && route_sel == 4'h5 ##1 (power_good && !route_load)[*3]
      |-> txd_pin_out == $past(engine_txd) && engine_rxd == $past(rxd_pin); endproperty
   a_eng: assert property (p_eng) else $error("engine route not followed");
   property p_none; route_load && power_good && route_sel == 4'hf ##1 (power_good && !route_load)[*3]
      |-> !(|txd_pin_oe) && !(|tx_request_pin_oe) && &engine_rxd; endproperty
   a_none: assert property (p_none) else $error("pins not released");
endmodule
bind bdp_port_mux bdp_port_mux_chk #(.NUM_CH(NUM_CH)) bdp_port_mux_chk_i (.clk, .resetn,
   .power_good, .route_load, .route_sel, .engine_txd, .engine_tx_request_n, .rxd_pin,
   .engine_rxd, .txd_pin_out,
   .txd_pin_oe, .tx_request_pin_out, .tx_request_pin_oe);

// file: bdp_port_mux_tb_top.sv
module bdp_port_mux_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   reg clk = 0, resetn = 0, pg = 1, ld = 0;
   reg [3:0] sel = 0;
   reg [1:0] etx = 0, erq = 3, atx = 0, aoe = 0, arq = 3, aqe = 0;
   wire [1:0] erx, arx, tpo, toe, rpo, roe, rxd;
   int bad_count = 0, checks = 0, m = 0;
   // note: route mode in [9:8], expected pins {roe, toe, rpo, tpo} in [7:0]
   logic [9:0] q[$];
   logic [9:0] note;
   logic [7:0] prev_pins = 8'hfc;
   logic [1:0] rx_exp;
   logic pv = 1'b0;
   always #2.5 clk = ~clk;
   bdp_port_mux bdp_port_mux_i (.clk(clk), .resetn(resetn), .power_good(pg), .route_sel(sel),
      .route_load(ld), .engine_txd(etx), .engine_tx_request_n(erq), .engine_rxd(erx),
      .alt_txd_out(atx), .alt_txd_oe(aoe), .alt_txreq_out(arq), .alt_txreq_oe(aqe),
      .alt_rxd_in(arx), .txd_pin_out(tpo), .txd_pin_oe(toe), .tx_request_pin_out(rpo),
      .tx_request_pin_oe(roe), .rxd_pin(rxd));
   bdp_bus_driver_model bdp_bus_driver_model_i (.txd_pin_out(tpo), .txd_pin_oe(toe),
      .tx_request_pin_out(rpo), .tx_request_pin_oe(roe), .rxd_pin(rxd));
   task chk(input string name, input [7:0] seen, input [7:0] exp);
      checks++;
      if (seen !== exp) begin
         bad_count++;
         $display("BAD %s exp %h seen %h", name, exp, seen);
      end
   endtask
   task give_verdict;
      $display("checks %0d bad_count %0d", checks, bad_count);
      if (bad_count == 0 && checks > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   // random inputs for one cycle, pins expected after the next edge
   task step;
      @(negedge clk);
      {etx, erq, atx, aoe, arq, aqe} = 12'($urandom);
      q.push_back({m[1:0],
         m == 1 ? {4'hf, erq, etx} : m == 2 ? {aqe, aoe, arq, atx} : m == 3 ? 8'h0c : 8'hfc});
   endtask
   // compare pins against the oldest note; receive outputs follow the driver model's
   // line as seen one cycle earlier, so they are checked only on back-to-back notes
   always @(posedge clk) begin
      if (q.size() > 0) begin
         #1;
         note = q.pop_front();
         rx_exp = (prev_pins[1:0] & prev_pins[5:4]) | prev_pins[3:2] | ~prev_pins[7:6];
         chk("pins", {roe, toe, rpo, tpo}, note[7:0]);
         if (pv) begin
            chk("engine_rxd", {6'h0, erx}, note[9:8] == 2'h1 ? {6'h0, rx_exp} : 8'h03);
            chk("alt_rxd_in", {6'h0, arx}, note[9:8] == 2'h2 ? {6'h0, rx_exp} : 8'h03);
         end
         prev_pins = note[7:0];
         pv = 1'b1;
      end else begin
         pv = 1'b0;
      end
   end
   initial begin
      repeat (3000) @(posedge clk);
      bad_count++;
      give_verdict();
   end
   // reset, the engine, alternate and none route codes, then loss of supply
   initial begin
      void'($urandom(11));
      repeat (12) @(posedge clk);
      @(negedge clk) resetn = 1;
      repeat (8) step();
      for (int k = 1; k < 4; k++) begin
         @(negedge clk) {sel, ld} = {k[1:0], k[1:0], 1'b1};
         @(negedge clk) {ld, m} = {1'b0, k};
         repeat (20) step();
      end
      @(negedge clk) {pg, ld, m} = {2'b01, 32'd0};
      repeat (4) step();
      {pg, ld} = 2'b10;
      repeat (4) step();
      // engine route again, then a reset in mid-run
      @(negedge clk) {sel, ld} = {4'h5, 1'b1};
      @(negedge clk) {ld, m} = {1'b0, 32'd1};
      repeat (6) step();
      @(negedge clk) {resetn, m} = {1'b0, 32'd0};
      repeat (3) step();
      resetn = 1;
      repeat (4) step();
      repeat (2) @(posedge clk);
      #2 give_verdict();
   end
endmodule
